// ==== common/icb_defs.svh ====
// Constants for the invert, compare and decimal adjust datapath
// Notes on behaviour
// [RQ1] Invert all destination bits, opcodes 60/61, 4 cycles
// [RQ2] Invert: Z on zero, S bit7, V cleared
// [RQ3] Compare subtracts for flags only, opcodes A2-A6
// [RQ4] Compare: C borrow, Z, S, V; D,H kept
// [RQ5] Opcode C2 branches relative when operands equal
// [RQ6] Opcode D2 branches relative when operands differ
// [RQ7] Compare-step-jump always increments source pointer
// [RQ8] Compare-step-jump leaves flags untouched
// [RQ9] Compare-step-jump: 18 cycles taken, 16 not
// [RQ10] Relative offset is signed, +127 to -128
// [RQ11] Adjust after add: add 00/06/60/66, carry on 6x
// [RQ12] Adjust after subtract: add 00/FA/A0/9A
// [RQ13] Adjust result undefined for non-BCD input
// [RQ14] Adjust flags: C per table, Z, S; D,H kept
// [RQ15] Adjust opcodes 40/41, 4 cycles
// [RQ16] Decimal flag selects add or subtract correction
`ifndef ICB_DEFS_SVH
`define ICB_DEFS_SVH
`define ICB_OP_INV_R 8'h60
`define ICB_OP_INV_IR 8'h61
`define ICB_OP_DA_R 8'h40
`define ICB_OP_DA_IR 8'h41
`define ICB_OP_CMP_RR 8'hA2
`define ICB_OP_CMP_RIR 8'hA3
`define ICB_OP_CMP_GG 8'hA4
`define ICB_OP_CMP_GIG 8'hA5
`define ICB_OP_CMP_IM 8'hA6
`define ICB_OP_CSJ_EQ 8'hC2
`define ICB_OP_CSJ_NE 8'hD2
`define ICB_CYC_SHORT 8'h04
`define ICB_CYC_CMP_LONG 8'h06
`define ICB_CYC_TAKEN 8'h12
`define ICB_CYC_NOTAKEN 8'h10
`define ICB_FLG_C 7
`define ICB_FLG_Z 6
`define ICB_FLG_S 5
`define ICB_FLG_V 4
`define ICB_FLG_D 3
`define ICB_FLG_H 2
`define ICB_FLAGS_RST 8'h00
`define ICB_PC_RST 16'h0000
`endif

// ==== common/icb_pkg.sv ====
// Types for the invert, compare and decimal adjust datapath
package icb_pkg;
   typedef enum logic [1:0] {ICB_IDLE, ICB_BUSY} icb_state_t;
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] dst;
      logic [7:0] src;
      logic [7:0] src_ptr;
      logic [7:0] rel;
      logic [15:0] pc;
      logic [7:0] flags;
   } icb_req_t;
   typedef struct packed {
      logic [7:0] dst;
      logic dst_we;
      logic [7:0] src_ptr;
      logic ptr_we;
      logic [15:0] pc;
      logic pc_we;
      logic [7:0] flags;
      logic flags_we;
   } icb_res_t;
   typedef struct packed {
      icb_state_t state;
      logic [7:0] cnt;
      icb_res_t res;
      logic done;
   } icb_regs_t;
endpackage : icb_pkg

// ==== verilog/icb_da_adj.sv ====
// Decimal adjust correction table
`timescale 1ns/100ps
module icb_da_adj
   import icb_pkg::*;
(
   // Operand and prior flags
   input wire logic [7:0] val,
   input wire logic c_in,
   input wire logic h_in,
   input wire logic sub_mode,
   // Correction
   output logic [7:0] add_val,
   output logic c_out
);
   logic [3:0] hi;
   logic [3:0] lo;
   always_comb begin
      hi = val[7:4];
      lo = val[3:0];
      add_val = 8'h00;
      c_out = 1'b0;
      // Unlisted combinations give no correction; their value is undefined anyway [RQ13]
      if (sub_mode) begin // [RQ16]
         if (!c_in && h_in && hi <= 4'h8 && lo >= 4'h6) begin // [RQ12]
            add_val = 8'hFA;
         end else if (c_in && !h_in && hi >= 4'h7 && lo <= 4'h9) begin
            add_val = 8'hA0;
            c_out = 1'b1;
         end else if (c_in && h_in && hi >= 4'h6 && lo >= 4'h6) begin
            add_val = 8'h9A;
            c_out = 1'b1;
         end
      end else begin
         if (!c_in) begin // [RQ11]
            if (!h_in && hi <= 4'h8 && lo >= 4'hA) begin
               add_val = 8'h06;
            end else if (h_in && hi <= 4'h9 && lo <= 4'h3) begin
               add_val = 8'h06;
            end else if (!h_in && hi >= 4'hA && lo <= 4'h9) begin
               add_val = 8'h60;
               c_out = 1'b1;
            end else if (!h_in && hi >= 4'h9 && lo >= 4'hA) begin
               add_val = 8'h66;
               c_out = 1'b1;
            end else if (h_in && hi >= 4'hA && lo <= 4'h3) begin
               add_val = 8'h66;
               c_out = 1'b1;
            end
         end else begin
            if (!h_in && hi <= 4'h2 && lo <= 4'h9) begin
               add_val = 8'h60;
               c_out = 1'b1;
            end else if (!h_in && hi <= 4'h2 && lo >= 4'hA) begin
               add_val = 8'h66;
               c_out = 1'b1;
            end else if (h_in && hi <= 4'h3 && lo <= 4'h3) begin
               add_val = 8'h66;
               c_out = 1'b1;
            end
         end
      end
   end
endmodule : icb_da_adj

// ==== verilog/icb_unit.sv ====
// Execution unit for invert, compare, compare-step-jump and decimal adjust
`timescale 1ns/100ps
`include "icb_defs.svh"
module icb_unit
   import icb_pkg::*;
#(
   // Instruction lengths in clock cycles
   parameter logic [7:0] CYC_SHORT = `ICB_CYC_SHORT,
   parameter logic [7:0] CYC_CMP_LONG = `ICB_CYC_CMP_LONG,
   parameter logic [7:0] CYC_TAKEN = `ICB_CYC_TAKEN,
   parameter logic [7:0] CYC_NOTAKEN = `ICB_CYC_NOTAKEN
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Instruction request from decode
   input wire logic req_valid,
   input wire icb_req_t req,
   output logic req_ready,
   // Results to register file, flags and program counter
   output icb_res_t res,
   output logic res_valid,
   output logic illegal_op
);
   icb_regs_t st_r;
   icb_regs_t st_nxt;
   logic [7:0] da_add;
   logic da_c;
   logic [8:0] diff;
   logic [7:0] inv;
   logic [7:0] da_sum;
   logic ovf;

   // The end pulse is raised when the count reaches two, so shorter lengths cannot be served
   if (CYC_SHORT < 8'h02 || CYC_CMP_LONG < 8'h02 || CYC_TAKEN < 8'h02 || CYC_NOTAKEN < 8'h02) begin : g_cyc_check
      $error("icb_unit: every instruction length must be at least two cycles");
   end

   icb_da_adj u_da (
      .val(req.dst),
      .c_in(req.flags[`ICB_FLG_C]),
      .h_in(req.flags[`ICB_FLG_H]),
      .sub_mode(req.flags[`ICB_FLG_D]),
      .add_val(da_add),
      .c_out(da_c)
   );

   assign diff = {1'b0, req.dst} - {1'b0, req.src};
   assign inv = ~req.dst;
   assign da_sum = req.dst + da_add;
   assign ovf = (req.dst[7] != req.src[7]) && (diff[7] != req.dst[7]);
   assign req_ready = (st_r.state == ICB_IDLE);
   assign res = st_r.res;
   assign res_valid = st_r.done;
   // Only an unknown opcode enters the busy state with a count of one
   assign illegal_op = (st_r.state == ICB_BUSY) && (st_r.cnt == 8'h01);

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      case (st_r.state)
         ICB_IDLE: begin
            if (req_valid) begin
               st_nxt.res = '0;
               st_nxt.res.flags = req.flags;
               st_nxt.res.pc = req.pc;
               st_nxt.res.src_ptr = req.src_ptr;
               st_nxt.res.dst = req.dst;
               st_nxt.cnt = CYC_SHORT;
               case (req.opcode)
                  `ICB_OP_INV_R, `ICB_OP_INV_IR: begin
                     st_nxt.res.dst = inv; // [RQ1]
                     st_nxt.res.dst_we = 1'b1;
                     st_nxt.res.flags_we = 1'b1;
                     st_nxt.res.flags[`ICB_FLG_Z] = (inv == 8'h00); // [RQ2]
                     st_nxt.res.flags[`ICB_FLG_S] = inv[7];
                     st_nxt.res.flags[`ICB_FLG_V] = 1'b0;
                  end
                  `ICB_OP_CMP_RR, `ICB_OP_CMP_RIR, `ICB_OP_CMP_GG, `ICB_OP_CMP_GIG, `ICB_OP_CMP_IM: begin
                     if (req.opcode != `ICB_OP_CMP_RR) begin
                        st_nxt.cnt = CYC_CMP_LONG;
                     end
                     st_nxt.res.flags_we = 1'b1; // [RQ3]
                     st_nxt.res.flags[`ICB_FLG_C] = diff[8]; // [RQ4]
                     st_nxt.res.flags[`ICB_FLG_Z] = (diff[7:0] == 8'h00);
                     st_nxt.res.flags[`ICB_FLG_S] = diff[7];
                     st_nxt.res.flags[`ICB_FLG_V] = ovf;
                  end
                  `ICB_OP_CSJ_EQ, `ICB_OP_CSJ_NE: begin
                     st_nxt.res.src_ptr = req.src_ptr + 8'h01; // [RQ7]
                     st_nxt.res.ptr_we = 1'b1;
                     st_nxt.cnt = CYC_NOTAKEN; // [RQ9]
                     // Flags pass through with no write [RQ8]
                     if ((diff[7:0] == 8'h00) == (req.opcode == `ICB_OP_CSJ_EQ)) begin // [RQ5] [RQ6]
                        st_nxt.res.pc = req.pc + {{8{req.rel[7]}}, req.rel}; // [RQ10]
                        st_nxt.res.pc_we = 1'b1;
                        st_nxt.cnt = CYC_TAKEN;
                     end
                  end
                  `ICB_OP_DA_R, `ICB_OP_DA_IR: begin
                     st_nxt.res.dst = da_sum; // [RQ15]
                     st_nxt.res.dst_we = 1'b1;
                     st_nxt.res.flags_we = 1'b1;
                     st_nxt.res.flags[`ICB_FLG_C] = da_c; // [RQ14]
                     st_nxt.res.flags[`ICB_FLG_Z] = (da_sum == 8'h00);
                     st_nxt.res.flags[`ICB_FLG_S] = da_sum[7];
                  end
                  default: begin
                     // Unknown opcode: one busy cycle and no writes
                     st_nxt.cnt = 8'h01;
                  end
               endcase
               st_nxt.state = ICB_BUSY;
            end
         end
         ICB_BUSY: begin
            st_nxt.cnt = st_r.cnt - 8'h01;
            if (st_r.cnt == 8'h02 || st_r.cnt <= 8'h01) begin
               st_nxt.done = (st_r.cnt == 8'h02) || (st_r.cnt <= 8'h01 && !st_r.done);
               st_nxt.state = ICB_IDLE;
            end
         end
         default: begin
            st_nxt.state = ICB_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{state: ICB_IDLE, cnt: 8'h00, res: '0, done: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : icb_unit

// ==== verification/icb_unit_props.sv ====
// Checker for the invert, compare and decimal adjust unit
`timescale 1ns/100ps
module icb_unit_props
   import icb_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Request and result
   input wire logic req_valid,
   input wire icb_req_t req,
   input wire logic req_ready,
   input wire icb_res_t res,
   input wire logic res_valid,
   input wire logic illegal_op
);
   icb_req_t q_r;
   wire tk = req_valid && req_ready;
   wire [7:0] op = q_r.opcode;
   wire [15:0] tgt = q_r.pc + {{8{q_r.rel[7]}}, q_r.rel};
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) q_r <= '0;
      else if (tk) q_r <= req;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_take_busy: assert property (tk |=> !req_ready) else $error("ready after take");
   chk_done_bound: assert property (tk |-> ##[1:18] res_valid) else $error("no end");
   chk_valid_pulse: assert property (res_valid |=> !res_valid) else $error("long valid");
   chk_inv_value: assert property (res_valid && op[7:1] == 7'h30 |-> res.dst == ~q_r.dst
      && !res.flags[4] && res.flags[7] == q_r.flags[7]) else $error("bad invert");
   chk_cmp_flags: assert property (res_valid && op inside {[8'hA2:8'hA6]} |-> !res.dst_we
      && res.flags[7] == (q_r.dst < q_r.src) && res.flags[6] == (q_r.dst == q_r.src)) else $error("bad cmp");
   chk_step_ptr: assert property (res_valid && (op == 8'hC2 || op == 8'hD2) |-> res.ptr_we
      && res.src_ptr == q_r.src_ptr + 8'h01 && !res.flags_we) else $error("bad ptr");
   chk_jump_eq: assert property (res_valid && op == 8'hC2 && q_r.dst == q_r.src |->
      res.pc_we && res.pc == tgt) else $error("bad eq jump");
   chk_jump_ne: assert property (res_valid && op == 8'hD2 && q_r.dst != q_r.src |->
      res.pc_we && res.pc == tgt) else $error("bad ne jump");
   chk_jump_skip: assert property (res_valid && (op == 8'hC2 && q_r.dst != q_r.src || op == 8'hD2
      && q_r.dst == q_r.src) |-> !res.pc_we && res.pc == q_r.pc) else $error("bad fall through");
   chk_da_keep: assert property (res_valid && op[7:1] == 7'h20 |->
      res.flags[3:2] == q_r.flags[3:2] && res.flags[6] == (res.dst == 8'h00)) else $error("bad adjust");
   chk_illegal_quiet: assert property (illegal_op |-> !res.dst_we && !res.pc_we) else $error("illegal wrote");
   cov_jump: cover property (res_valid && op == 8'hC2 && q_r.dst == q_r.src);
   cov_no_jump: cover property (res_valid && op == 8'hD2 && q_r.dst == q_r.src);
   cov_adjust: cover property (res_valid && op == 8'h41);
   cov_illegal: cover property (illegal_op);
endmodule : icb_unit_props
bind icb_unit icb_unit_props icb_unit_props_inst (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
   .req(req), .req_ready(req_ready), .res(res), .res_valid(res_valid), .illegal_op(illegal_op));

// ==== verification/testbench.sv ====
// Random and corner-case bench for the invert, compare and decimal adjust unit
`timescale 1ns/100ps
module testbench
   import icb_pkg::*;
();
   logic mclk = 0;
   logic rst_b = 0;
   logic req_valid = 0;
   icb_req_t req = '0;
   logic req_ready, res_valid, illegal_op, ill, t;
   icb_res_t res;
   int failures = 0;
   int compares = 0;
   int seed = 32'h0424;
   int n;
   logic [7:0] d, s, e;
   // Operand, flags in, result, carry out
   logic [31:0] da_tab [8] = '{32'h3C004200, 32'hA0000001, 32'h15807501, 32'h33043900,
      32'h31083100, 32'h2F0C2900, 32'h95883501, 32'h668C0001};
   icb_unit icb_unit_inst (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .res(res), .res_valid(res_valid), .illegal_op(illegal_op));
   initial forever #50 mclk = ~mclk;
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic run(input logic [7:0] op, dv, sv, fl, rl);
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{op, dv, sv, 8'($random(seed)), rl, 16'($random(seed)), fl};
      @(posedge mclk);
      req_valid <= 1'b0;
      n = 0;
      ill = 1'b0;
      do begin
         @(negedge mclk);
         n++;
         ill |= illegal_op;
      end while (res_valid !== 1'b1 && n < 40);
      @(negedge mclk);
      ill |= illegal_op;
   endtask : run
   function automatic logic [7:0] cmpf(logic [7:0] a, b, f);
      logic [7:0] r;
      r = a - b;
      return {a < b, r == 8'h00, r[7], a[7] != b[7] && r[7] != a[7], f[3:0]};
   endfunction : cmpf
   task automatic stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   initial begin
      #3000000;
      failures++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         d = (i == 2) ? 8'hFF : 8'($random(seed));
         // Equal operands on a jump-on-unequal give the not-taken corner
         s = (i < 2 || i == 3) ? d : 8'($random(seed));
         run(8'h60 + 8'(i % 2), d, s, s, 8'h00);
         chk("inv cyc", 16'(n), 16'h0004);
         chk("inv", {res.flags[7:2], res.dst}, {s[7], d == 8'hFF, ~d[7], 1'b0, s[3:2], ~d});
         run(8'hA2 + 8'(i % 5), d, s, s, 8'h00);
         e = cmpf(d, s, s);
         chk("cmp cyc", 16'(n), (i % 5 == 0) ? 16'h0004 : 16'h0006);
         chk("cmp", {res.dst_we, res.flags[7:2]}, {1'b0, e[7:2]});
         e = (i % 4 == 0) ? 8'h7F : (i % 4 == 1) ? 8'h80 : 8'($random(seed));
         run(i[1] ? 8'hD2 : 8'hC2, d, s, s, e);
         t = i[1] ^ (d == s);
         chk("ptr", {res.ptr_we, res.flags_we, res.src_ptr}, {2'b10, req.src_ptr + 8'h01});
         chk("cyc", 16'(n), t ? 16'h0012 : 16'h0010);
         chk("rdy", {req_ready, res_valid}, 2'b10);
         if (t)
            chk("pc", res.pc, req.pc + {{8{e[7]}}, e});
         else
            chk("pc", res.pc, req.pc);
      end
      for (int i = 0; i < 8; i++) begin
         e = da_tab[i][15:8];
         run(i[0] ? 8'h41 : 8'h40, da_tab[i][31:24], 8'h00, da_tab[i][23:16], 8'h00);
         chk("da", {res.dst, res.flags[7:5], res.flags[3:2]},
            {e, da_tab[i][0], e == 8'h00, e[7], da_tab[i][19:18]});
         chk("da cyc", 16'(n), 16'h0004);
      end
      run(8'hFF, 8'h12, 8'h34, 8'h00, 8'h00);
      chk("ill", {ill, res.dst_we, res.pc_we, res.flags_we}, 4'b1000);
      stop_test();
   end
endmodule : testbench
